// [hdl/lpio_pkg.sv]
// Purpose: Constants shared by the low port I/O block.
// Assumes: Special-function-register accesses arrive on the core clock.
package lpio_pkg;
  localparam logic [7:0] PAGE_F = 8'h0F;
  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_PORT3_LATCH = 8'hB0;
  localparam logic [7:0] ADDR_PORT0_DRIVE = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_DRIVE = 8'hA5;
  localparam logic [7:0] ADDR_PORT2_DRIVE = 8'hA6;
  localparam logic [7:0] ADDR_PORT3_DRIVE = 8'hA7;
  localparam logic [7:0] ADDR_PORT1_ANADIG = 8'hAD;
  localparam logic [7:0] ADDR_ROUTE_CFG_C = 8'hE3;
  localparam int PULLUP_OFF_BIT = 7;
  localparam int ROUTE_EN_BIT = 6;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] ANADIG_RST = 8'hFF;
  localparam logic [7:0] ROUTE_CFG_RST = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

// [hdl/lpio_port_drv.sv]
`timescale 1ns/100ps
// Purpose: Pin driver and pullup logic of one byte-wide port.
// Assumes: Overrides already merged by the top; priority is resolved there.
// Notes: Purely combinational; assertions use the core clock.
module lpio_port_drv (
  // Clock and reset for checks
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Port control
  lpio_port_if.drv p
);
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      logic val;
      logic push;
      assign val = p.ovr_en[gi] ? p.ovr_val[gi] : p.latch[gi];
      assign push = p.drive_sel[gi] & ~p.od_force[gi];
      always_comb begin
        p.pin_out[gi] = val;
        if (!p.route_en || p.ovr_kill[gi]) begin
          p.pin_oe[gi] = 1'b0;
        end else if (!val) begin
          p.pin_oe[gi] = 1'b1;
        end else begin
          p.pin_oe[gi] = push;
        end
      end
      // A pin driving low never fights its own pullup.
      assign p.pullup_en[gi] = ~p.pullup_off & p.digital_en[gi] & ~(p.pin_oe[gi] & ~val);
    end
  endgenerate

  chk_od_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ((~p.drive_sel & p.latch & ~p.ovr_en & p.pin_oe) == 8'h00))
    else $error("open-drain pin with latch one is driven");
  chk_push_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    p.route_en |-> ((p.drive_sel & ~p.od_force & ~p.ovr_kill & ~p.pin_oe) == 8'h00))
    else $error("push-pull pin not driven");
  chk_od_forced: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ((p.od_force & p.pin_oe & p.pin_out) == 8'h00))
    else $error("forced open-drain pin driven high");
  chk_route_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !p.route_en |-> (p.pin_oe == 8'h00))
    else $error("pin driven while routing disabled");
  chk_pullup_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    p.pullup_off |-> (p.pullup_en == 8'h00))
    else $error("pullup on while globally off");
  chk_analog_pullup: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ((~p.digital_en & p.pullup_en) == 8'h00))
    else $error("pullup on for analog pin");
endmodule

// [hdl/lpio_port_if.sv]
`timescale 1ns/100ps
// Purpose: Carries one port's control and pin state between top and driver.
// Assumes: All signals on the core clock.
// Notes: One instance per port.
interface lpio_port_if;
  logic [7:0] latch;
  logic [7:0] drive_sel;
  logic [7:0] digital_en;
  logic [7:0] ovr_en;
  logic [7:0] ovr_val;
  logic [7:0] ovr_kill;
  logic [7:0] od_force;
  logic route_en;
  logic pullup_off;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pullup_en;
  modport ctrl (
    output latch, drive_sel, digital_en, ovr_en, ovr_val, ovr_kill, od_force, route_en, pullup_off,
    input pin_out, pin_oe, pullup_en
  );
  modport drv (
    input latch, drive_sel, digital_en, ovr_en, ovr_val, ovr_kill, od_force, route_en, pullup_off,
    output pin_out, pin_oe, pullup_en
  );
endinterface

// [hdl/lpio_top.sv]
`timescale 1ns/100ps
// Purpose: Low port I/O block for ports 0 to 3 with register access.
// Assumes: Crossbar and external memory interface logic sit outside.
// Notes: Read data appears one clock after the read strobe.
module lpio_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Special-function-register access
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rmw_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Crossbar peripheral assignments, ports 0 and 1; open-drain force, ports 0 to 3
  input wire logic [15:0] periph_sel_i,
  input wire logic [15:0] periph_val_i,
  input wire logic [31:0] periph_od_force_i,
  // External memory interface
  input wire logic external_memory_port_active_i,
  input wire logic external_memory_port_muxed_i,
  input wire logic [15:0] external_memory_port_addr_i,
  input wire logic [7:0] external_memory_port_data_i,
  input wire logic external_memory_port_data_oe_i,
  // Pins, ports 0 to 3 in byte order
  input wire logic [31:0] pin_in_i,
  output logic [31:0] pin_out_o,
  output logic [31:0] pin_oe_o,
  output logic [31:0] pin_pullup_o,
  // Routing and converter status
  output logic route_en_o,
  output logic [7:0] port1_route_skip_o,
  output logic [7:0] aux_analog_input_o
);
  logic [7:0] latch_r [4];
  logic [7:0] drive_r [4];
  logic [7:0] anadig_r;
  logic [7:0] route_cfg_c_r;
  logic [31:0] pin_meta_r;
  logic [31:0] pin_sync_r;
  logic [7:0] rdata_nxt;
  logic page_f;
  logic [1:0] lat_idx;
  logic lat_hit;
  logic [1:0] drv_idx;
  logic drv_hit;
  logic [7:0] external_memory_port_val [4];
  logic [7:0] external_memory_port_en [4];
  logic [7:0] external_memory_port_kill [4];
  logic [7:0] periph_en [4];
  logic [7:0] periph_v [4];
  logic route_en;
  logic pullup_off;

  lpio_port_if port_if [4] ();

  assign page_f = (sfr_page_i == lpio_pkg::PAGE_F);
  assign route_en = route_cfg_c_r[lpio_pkg::ROUTE_EN_BIT];
  assign pullup_off = route_cfg_c_r[lpio_pkg::PULLUP_OFF_BIT];

  // Data registers answer on every page.
  always_comb begin
    lat_hit = 1'b1;
    lat_idx = 2'h0;
    case (sfr_addr_i)
      lpio_pkg::ADDR_PORT0_LATCH: lat_idx = 2'h0;
      lpio_pkg::ADDR_PORT1_LATCH: lat_idx = 2'h1;
      lpio_pkg::ADDR_PORT2_LATCH: lat_idx = 2'h2;
      lpio_pkg::ADDR_PORT3_LATCH: lat_idx = 2'h3;
      default: lat_hit = 1'b0;
    endcase
  end

  // Drive-select registers answer only when page F is selected.
  always_comb begin
    drv_hit = page_f;
    drv_idx = 2'h0;
    case (sfr_addr_i)
      lpio_pkg::ADDR_PORT0_DRIVE: drv_idx = 2'h0;
      lpio_pkg::ADDR_PORT1_DRIVE: drv_idx = 2'h1;
      lpio_pkg::ADDR_PORT2_DRIVE: drv_idx = 2'h2;
      lpio_pkg::ADDR_PORT3_DRIVE: drv_idx = 2'h3;
      default: drv_hit = 1'b0;
    endcase
  end

  // Output latches.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        latch_r[i] <= lpio_pkg::LATCH_RST;
      end
    end else if (sfr_wr_i && lat_hit) begin
      latch_r[lat_idx] <= sfr_wdata_i;
    end
  end

  // Drive-select registers.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        drive_r[i] <= lpio_pkg::DRIVE_RST;
      end
    end else if (sfr_wr_i && drv_hit) begin
      drive_r[drv_idx] <= sfr_wdata_i;
    end
  end

  // Port 1 analog or digital selection.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      anadig_r <= lpio_pkg::ANADIG_RST;
    end else if (sfr_wr_i && page_f && (sfr_addr_i == lpio_pkg::ADDR_PORT1_ANADIG)) begin
      anadig_r <= sfr_wdata_i;
    end
  end

  // Routing configuration holding the enable and the global pullup-off bit.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_cfg_c_r <= lpio_pkg::ROUTE_CFG_RST;
    end else if (sfr_wr_i && page_f && (sfr_addr_i == lpio_pkg::ADDR_ROUTE_CFG_C)) begin
      route_cfg_c_r <= sfr_wdata_i;
    end
  end

  // Pins are asynchronous to the core, so they pass two flops first.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 32'h0000_0000;
      pin_sync_r <= 32'h0000_0000;
    end else begin
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Read multiplexer.
  always_comb begin
    rdata_nxt = 8'h00;
    if (lat_hit) begin
      if (sfr_rmw_i) begin
        rdata_nxt = latch_r[lat_idx];
      end else begin
        rdata_nxt = pin_sync_r[lat_idx*8 +: 8];
        if (lat_idx == 2'h1) begin
          rdata_nxt = pin_sync_r[15:8] & anadig_r;
        end
      end
    end else if (drv_hit) begin
      rdata_nxt = drive_r[drv_idx];
    end else if (page_f && (sfr_addr_i == lpio_pkg::ADDR_PORT1_ANADIG)) begin
      rdata_nxt = anadig_r;
    end else if (page_f && (sfr_addr_i == lpio_pkg::ADDR_ROUTE_CFG_C)) begin
      rdata_nxt = route_cfg_c_r;
    end
  end

  // Read data is held until the next read strobe.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rdata_nxt;
    end
  end

  // External memory takes pins only while an off-chip access runs.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      external_memory_port_val[i] = 8'h00;
      external_memory_port_en[i] = 8'h00;
      external_memory_port_kill[i] = 8'h00;
    end
    if (external_memory_port_active_i) begin
      if (!external_memory_port_muxed_i) begin
        external_memory_port_en[1] = 8'hFF;
        external_memory_port_val[1] = external_memory_port_addr_i[15:8];
      end
      external_memory_port_en[2] = 8'hFF;
      external_memory_port_val[2] = external_memory_port_muxed_i ? external_memory_port_addr_i[15:8] : external_memory_port_addr_i[7:0];
      external_memory_port_en[3] = 8'hFF;
      external_memory_port_val[3] = external_memory_port_data_i;
      // Reads release the data byte so the memory can drive it.
      external_memory_port_kill[3] = external_memory_port_data_oe_i ? 8'h00 : 8'hFF;
    end
  end

  // Peripheral routing only on ports 0 and 1; analog pins are skipped.
  always_comb begin
    periph_en[0] = periph_sel_i[7:0];
    periph_v[0] = periph_val_i[7:0];
    periph_en[1] = periph_sel_i[15:8] & anadig_r;
    periph_v[1] = periph_val_i[15:8];
    periph_en[2] = 8'h00;
    periph_v[2] = 8'h00;
    periph_en[3] = 8'h00;
    periph_v[3] = 8'h00;
  end

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      assign port_if[gp].latch = latch_r[gp];
      assign port_if[gp].drive_sel = drive_r[gp];
      assign port_if[gp].digital_en = (gp == 1) ? anadig_r : 8'hFF;
      assign port_if[gp].ovr_en = external_memory_port_en[gp] | periph_en[gp];
      assign port_if[gp].ovr_val = (external_memory_port_en[gp] & external_memory_port_val[gp]) | (~external_memory_port_en[gp] & periph_v[gp]);
      assign port_if[gp].ovr_kill = external_memory_port_kill[gp];
      assign port_if[gp].od_force = periph_od_force_i[gp*8 +: 8];
      assign port_if[gp].route_en = route_en;
      assign port_if[gp].pullup_off = pullup_off;
      assign pin_out_o[gp*8 +: 8] = port_if[gp].pin_out;
      assign pin_oe_o[gp*8 +: 8] = port_if[gp].pin_oe;
      assign pin_pullup_o[gp*8 +: 8] = port_if[gp].pullup_en;
      lpio_port_drv u_drv (
        .core_clk_i (core_clk_i),
        .rst_n_i (rst_n_i),
        .p (port_if[gp])
      );
    end
  endgenerate

  assign route_en_o = route_en;
  assign port1_route_skip_o = ~anadig_r;
  assign aux_analog_input_o = ~anadig_r;

  sequence seq_p1_write;
    sfr_wr_i && (sfr_addr_i == lpio_pkg::ADDR_PORT1_LATCH);
  endsequence

  sequence seq_p2_pin_read;
    sfr_rd_i && !sfr_rmw_i && (sfr_addr_i == lpio_pkg::ADDR_PORT2_LATCH);
  endsequence

  sequence seq_p3_rmw_read;
    sfr_rd_i && sfr_rmw_i && (sfr_addr_i == lpio_pkg::ADDR_PORT3_LATCH);
  endsequence

  sequence seq_p1_pin_read;
    sfr_rd_i && !sfr_rmw_i && (sfr_addr_i == lpio_pkg::ADDR_PORT1_LATCH);
  endsequence

  chk_latch_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seq_p1_write |=> (latch_r[1] == $past(sfr_wdata_i)))
    else $error("port 1 latch did not load written value");
  chk_pin_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seq_p2_pin_read |=> (sfr_rdata_o == $past(pin_sync_r[23:16])))
    else $error("port 2 read did not return pin level");
  chk_rmw_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seq_p3_rmw_read |=> (sfr_rdata_o == $past(latch_r[3])))
    else $error("read-modify-write did not return latch");
  chk_analog_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    seq_p1_pin_read |=> ((sfr_rdata_o & ~$past(anadig_r)) == 8'h00))
    else $error("analog pin read not zero");
  chk_page_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (sfr_wr_i && !page_f && (sfr_addr_i == lpio_pkg::ADDR_PORT0_DRIVE)) |=> $stable(drive_r[0]))
    else $error("drive-select written off page F");
  chk_external_memory_port_port2: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (external_memory_port_active_i && external_memory_port_muxed_i) |-> (pin_out_o[23:16] == external_memory_port_addr_i[15:8]))
    else $error("port 2 not carrying upper address");
  chk_external_memory_port_port1: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (external_memory_port_active_i && !external_memory_port_muxed_i) |-> (pin_out_o[15:8] == external_memory_port_addr_i[15:8]))
    else $error("port 1 not carrying upper address");
  chk_analog_skip: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!external_memory_port_active_i && route_en) |-> ((~anadig_r & periph_sel_i[15:8] & (pin_out_o[15:8] ^ latch_r[1])) == 8'h00))
    else $error("routing took an analog pin");
endmodule

// [sim/low_port_io_config_tb_top.sv]
// Purpose: Self-checking bench for the low port block against a behavioural model.
// Assumes: Pin inputs stay stable for several cycles before any port read.
// Notes: Pins that float read as unknown to the model and are masked out.
`timescale 1ns/100ps
module low_port_io_config_tb_top;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0;
  logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata, skip, aux, d;
  logic [15:0] psel = 16'h0, pval = 16'h0, eaddr = 16'h0;
  logic [31:0] odf = 32'h0, ext_en = 32'hFFFFFFFF, ext_val = 32'h0, lvl, pout, poe, ppu;
  logic ea = 1'b0, emx = 1'b0, edoe = 1'b0, ren;
  logic [7:0] edata = 8'h00, sel1, cfg;
  logic [7:0] lat [4];
  logic [7:0] drv [4];
  logic [31:0] e_oe, e_out, e_pu, e_lvl, known;
  int err_count = 0, checked = 0, cyc = 0, seed = 32'h5e55, it, p;
  always #12.5 core_clk_i = ~core_clk_i;
  lpio_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_page_i(page),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rmw_i(rmw), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .periph_sel_i(psel), .periph_val_i(pval), .periph_od_force_i(odf), .external_memory_port_active_i(ea),
    .external_memory_port_muxed_i(emx), .external_memory_port_addr_i(eaddr), .external_memory_port_data_i(edata), .external_memory_port_data_oe_i(edoe),
    .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(poe), .pin_pullup_o(ppu), .route_en_o(ren),
    .port1_route_skip_o(skip), .aux_analog_input_o(aux));
  lpio_pin_model u_pins (.core_clk_i(core_clk_i), .pin_out_i(pout), .pin_oe_i(poe),
    .pin_pullup_i(ppu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(lvl));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] v);
    @(posedge core_clk_i);
    #2 wr = 1'b1; addr = a; page = pg; wdata = v;
    @(posedge core_clk_i);
    #2 wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] pg, input logic m, output logic [7:0] v);
    @(posedge core_clk_i);
    #2 rd = 1'b1; addr = a; page = pg; rmw = m;
    @(posedge core_clk_i);
    #2 rd = 1'b0; rmw = 1'b0; v = rdata;
  endtask
  task automatic calc();
    int i, q;
    logic v, o;
    for (i = 0; i < 32; i++) begin
      q = i / 8;
      v = lat[q][i%8];
      if (q < 2 && psel[i] && (q == 0 || sel1[i%8])) v = pval[i];
      if (ea && q == 1 && !emx) v = eaddr[8+i%8];
      if (ea && q == 2) v = emx ? eaddr[8+i%8] : eaddr[i%8];
      if (ea && q == 3) v = edata[i%8];
      o = cfg[6] && (!v || (drv[q][i%8] && !odf[i]));
      if (q == 3 && ea && !edoe) o = 1'b0;
      e_oe[i] = o;
      e_out[i] = v & o;
      e_pu[i] = !cfg[7] && (q != 1 || sel1[i%8]) && !(o && !v);
      e_lvl[i] = o ? v : (ext_en[i] ? ext_val[i] : 1'b1);
      known[i] = o | ext_en[i] | e_pu[i];
      if (q == 1 && !sel1[i%8]) begin
        e_lvl[i] = 1'b0;
        known[i] = 1'b1;
      end
    end
  endtask
  task automatic check_all(input string tname);
    calc();
    check("pin_oe", poe, e_oe);
    check("pin_out", pout & poe, e_out);
    check("pin_pullup", ppu, e_pu);
    check("skip", {skip, aux}, {~sel1, ~sel1});
    check("route_en", ren, cfg[6]);
    for (p = 0; p < 4; p++) begin
      rd_reg(8'h80 + 8'h10 * p[7:0], 8'h00, 1'b0, d);
      check("port_read", d & known[8*p+:8], e_lvl[8*p+:8] & known[8*p+:8]);
      rd_reg(8'h80 + 8'h10 * p[7:0], 8'h00, 1'b1, d);
      check("rmw_read", d, lat[p]);
      rd_reg(lpio_pkg::ADDR_PORT0_DRIVE + p[7:0], lpio_pkg::PAGE_F, 1'b0, d);
      check("drive_read", d, drv[p]);
    end
    $display("test done: %s", tname);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    for (p = 0; p < 4; p++) begin
      lat[p] = lpio_pkg::LATCH_RST;
      drv[p] = lpio_pkg::DRIVE_RST;
    end
    sel1 = 8'hFF;
    cfg = 8'h00;
    repeat (20) @(posedge core_clk_i);
    #2 rst_n_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    check_all("reset");
    rd_reg(lpio_pkg::ADDR_PORT1_ANADIG, lpio_pkg::PAGE_F, 1'b0, d);
    check("anadig_read", d, 8'hFF);
    wr_reg(lpio_pkg::ADDR_PORT0_DRIVE, 8'h00, 8'h5A);
    wr_reg(lpio_pkg::ADDR_PORT1_LATCH, 8'h3C, 8'h33);
    lat[1] = 8'h33;
    rd_reg(8'h81, lpio_pkg::PAGE_F, 1'b0, d);
    check("unmapped", d, 8'h00);
    check_all("paging");
    for (it = 0; it < 24; it++) begin
      cfg = $random(seed);
      cfg[6] = (it % 4 != 3);
      sel1 = $random(seed);
      wr_reg(lpio_pkg::ADDR_ROUTE_CFG_C, lpio_pkg::PAGE_F, cfg);
      wr_reg(lpio_pkg::ADDR_PORT1_ANADIG, lpio_pkg::PAGE_F, sel1);
      for (p = 0; p < 4; p++) begin
        lat[p] = $random(seed);
        drv[p] = $random(seed);
        wr_reg(8'h80 + 8'h10 * p[7:0], 8'h00, lat[p]);
        wr_reg(lpio_pkg::ADDR_PORT0_DRIVE + p[7:0], lpio_pkg::PAGE_F, drv[p]);
      end
      @(posedge core_clk_i);
      #2 psel = $random(seed); pval = $random(seed); odf = $random(seed); eaddr = $random(seed);
      edata = $random(seed); ea = $random(seed); emx = $random(seed); edoe = $random(seed);
      ext_en = $random(seed); ext_val = $random(seed);
      repeat (4) @(posedge core_clk_i);
      check_all("random");
    end
    give_verdict();
  end
endmodule

// [sim/lpio_pin_model.sv]
// Purpose: Board around the port pins: outside drivers, weak pullups, floating wires.
// Assumes: Device drive wins over an outside driver on contention.
// Notes: A floating pin shows the inverse of its last level so no stale value reads back.
`timescale 1ns/100ps
module lpio_pin_model (
  // Clock
  input wire logic core_clk_i,
  // Device side
  input wire logic [31:0] pin_out_i,
  input wire logic [31:0] pin_oe_i,
  input wire logic [31:0] pin_pullup_i,
  // Outside drivers
  input wire logic [31:0] ext_en_i,
  input wire logic [31:0] ext_val_i,
  // Pin levels
  output logic [31:0] pin_level_o
);
  logic [31:0] float_r = 32'h0;
  always @(posedge core_clk_i) begin
    float_r <= ~pin_level_o;
  end
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                     | (~pin_oe_i & ~ext_en_i & (pin_pullup_i | float_r));
endmodule
